// file: hw/ssc_consts.vh
// constants for the supply supervisor control block
// assumes a 100 MHz always-on clock and comparator outputs high when supply is above threshold
// What this block does
// R1 - hold reset while power-on comparator says supply is low; never disabled
// R2 - hold reset while power-down comparator says supply is low; never disabled
// R3 - brown-out active: reset below selected level, release above its upper limit
// R4 - brown-out level picked from five by option storage, not a register
// R5 - power-on and power-down feed the reset hold register only when brown-out is disabled; their direct path resets always
// R6 - after start threshold passes, load option settings for brown-out
// R7 - brown-out disable only through option storage, loaded above lowest level
// R8 - variant without brown-out uses power-on and power-down comparators only
// R9 - level detector threshold from 3-bit field, seven internal levels
// R10 - field 111 compares external input against internal reference
// R11 - level detector works only while its enable bit is set
// R12 - detector flag shows above or below, drives external event line 16
// R13 - internal reference on whenever any user requests it
// R14 - ultra-low-power: reference off in stop and standby, 3 ms startup
// R15 - fast wakeup: leave low power without waiting for reference startup
// R16 - ultra-low-power: dependents off in low power, back after startup ends
// R17 - ready flag set once internal reference is ready
// R18 - comparators synchronised; power-on and power-down reset asserted at once, brown-out reset through registers, released synchronously
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH
// 3 ms at 100 MHz, sized to the startup counter
`define SSC_VREF_START_CYC 19'h4_93E0
`define SSC_CNT_W 19
`define SSC_LVL_EXT 3'h7
`define SSC_BOR_LVL_W 3
`define SSC_BOR_LVL_MAX 3'h4
`define SSC_BOR_LVL_RST 3'h0
`define SSC_SYNC_RST 2'h0
`endif

// file: hw/ssc_sync.v
// two-flop synchroniser for one comparator level
// assumes input may change at any time relative to the clock
`timescale 1ns/1ps
`include "ssc_consts.vh"
module ssc_sync (
    input wire clk_in,
    input wire rst_in,
    input wire d_in,
    output wire q_out
);
    reg [1:0] s_q;
    always @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= `SSC_SYNC_RST;
        end else begin
            s_q <= {s_q[0], d_in};
        end
    end
    assign q_out = s_q[1];
endmodule // ssc_sync

// file: hw/ssc_vref_ctrl.v
// internal reference control: request, low-power gating, startup wait, ready flag
// assumes lowpower_in is high for the whole of stop or standby
`timescale 1ns/1ps
`include "ssc_consts.vh"
module ssc_vref_ctrl #(
    parameter [`SSC_CNT_W-1:0] START_CYC = `SSC_VREF_START_CYC
) (
    input wire clk_in,
    input wire rst_in,
    input wire request_in,
    input wire lowpower_in,
    input wire ulp_in,
    input wire fwu_in,
    output reg vref_on_out,
    output reg ready_out,
    output reg hold_wake_out,
    output reg dep_enable_out
);
    reg [`SSC_CNT_W-1:0] cnt_q;
    reg fwu_q;
    reg lp_q;
    wire want = request_in && !(ulp_in && lowpower_in); // see R13 see R14
    always @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= {`SSC_CNT_W{1'b0}};
            fwu_q <= 1'b0;
            lp_q <= 1'b0;
            vref_on_out <= 1'b0;
            ready_out <= 1'b0;
            hold_wake_out <= 1'b0;
            dep_enable_out <= 1'b0;
        end else begin
            lp_q <= lowpower_in;
            // fast wakeup is sampled on entry, later writes do not matter
            if (lowpower_in && !lp_q) begin
                fwu_q <= fwu_in;
            end
            vref_on_out <= want;
            if (!want) begin
                cnt_q <= {`SSC_CNT_W{1'b0}};
                ready_out <= 1'b0;
            end else if (cnt_q != START_CYC) begin
                cnt_q <= cnt_q + 1'b1;
                ready_out <= 1'b0;
            end else begin
                ready_out <= 1'b1; // see R17
            end
            // stall wake only when reference was off and fast wakeup not chosen
            hold_wake_out <= want && !ready_out && ulp_in && !fwu_q && !lowpower_in; // see R15
            dep_enable_out <= ulp_in ? (want && ready_out) : !lowpower_in || want; // see R16
        end
    end
endmodule // ssc_vref_ctrl

// file: hw/ssc_top.v
// supply supervisor control: chip reset, brown-out, level detector, reference
// assumes comparator outputs are high when the supply is above the threshold
`timescale 1ns/1ps
`include "ssc_consts.vh"
module ssc_top #(
    parameter [`SSC_CNT_W-1:0] VREF_START_CYC = `SSC_VREF_START_CYC,
    parameter HAS_BROWNOUT = 1
) (
    // clock and reset
    input wire CORE_CLK_IN,
    input wire RST_IN,
    // analog comparators
    input wire POR_ABOVE_IN,
    input wire FALLING_SUPPLY_ABOVE_IN,
    input wire START_ABOVE_IN,
    input wire [4:0] BROWNOUT_ABOVE_LOW_IN,
    input wire [4:0] BROWNOUT_ABOVE_HIGH_IN,
    input wire [6:0] DETECTOR_ABOVE_IN,
    input wire EXTERNAL_DETECTOR_ABOVE_IN,
    // option storage
    input wire OPTION_VALID_IN,
    input wire [2:0] OPTION_BROWNOUT_LEVEL_IN,
    input wire OPTION_BROWNOUT_DISABLE_IN,
    // software control
    input wire [2:0] DETECTOR_LEVEL_SELECT_IN,
    input wire DETECTOR_ENABLE_BIT_IN,
    input wire REFERENCE_OFF_IN_LOWPOWER_IN,
    input wire FAST_WAKEUP_SELECT_IN,
    input wire LOWPOWER_IN,
    // reference users
    input wire ADC_REF_REQ_IN,
    input wire LCD_REF_REQ_IN,
    input wire COMP_REF_REQ_IN,
    // outputs
    output wire CHIP_RESET_OUT,
    output reg OPTION_LOAD_OUT,
    output reg DETECTOR_OUTPUT_FLAG_OUT,
    output wire EVENT_LINE16_OUT,
    output wire INTERNAL_REFERENCE_ON_OUT,
    output wire REFERENCE_READY_FLAG_OUT,
    output wire WAKE_HOLD_OUT,
    output wire REF_DEPENDENTS_ENABLE_OUT
);
    wire por_s;
    wire pdr_s;
    wire start_s;
    wire [4:0] bor_lo_s;
    wire [4:0] bor_hi_s;
    wire [6:0] det_s;
    wire ext_s;
    reg bor_rst_q;
    reg bor_dis_q;
    reg opt_done_q;
    reg [2:0] bor_lvl_q;
    reg rst_hold_q;
    wire dep_en;

    // one synchroniser per comparator level
    ssc_sync u_por (.clk_in(CORE_CLK_IN), .rst_in(RST_IN), .d_in(POR_ABOVE_IN),
        .q_out(por_s)); // see R18
    ssc_sync u_pdr (.clk_in(CORE_CLK_IN), .rst_in(RST_IN), .d_in(FALLING_SUPPLY_ABOVE_IN),
        .q_out(pdr_s));
    ssc_sync u_start (.clk_in(CORE_CLK_IN), .rst_in(RST_IN), .d_in(START_ABOVE_IN),
        .q_out(start_s));
    ssc_sync u_ext (.clk_in(CORE_CLK_IN), .rst_in(RST_IN), .d_in(EXTERNAL_DETECTOR_ABOVE_IN),
        .q_out(ext_s));
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_bor
            ssc_sync u_lo (.clk_in(CORE_CLK_IN), .rst_in(RST_IN),
                .d_in(BROWNOUT_ABOVE_LOW_IN[gi]), .q_out(bor_lo_s[gi]));
            ssc_sync u_hi (.clk_in(CORE_CLK_IN), .rst_in(RST_IN),
                .d_in(BROWNOUT_ABOVE_HIGH_IN[gi]), .q_out(bor_hi_s[gi]));
        end
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_det
            ssc_sync u_d (.clk_in(CORE_CLK_IN), .rst_in(RST_IN),
                .d_in(DETECTOR_ABOVE_IN[gi]), .q_out(det_s[gi]));
        end
    endgenerate

    // out-of-range option values clamp to the highest level
    function [2:0] clamp_lvl;
        input [2:0] v;
        begin
            clamp_lvl = (v > `SSC_BOR_LVL_MAX) ? `SSC_BOR_LVL_MAX : v;
        end
    endfunction

    wire bor_active = (HAS_BROWNOUT != 0) && !bor_dis_q; // see R8
    wire below_lo = !bor_lo_s[bor_lvl_q];
    wire above_hi = bor_hi_s[bor_lvl_q];

    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            opt_done_q <= 1'b0;
            OPTION_LOAD_OUT <= 1'b0;
            bor_lvl_q <= `SSC_BOR_LVL_RST;
            bor_dis_q <= 1'b0;
            bor_rst_q <= 1'b1;
            rst_hold_q <= 1'b1;
        end else begin
            // loading starts only once the start threshold is passed
            // drop the request on the taking edge so one answer is never read twice
            OPTION_LOAD_OUT <= start_s && !opt_done_q &&
                !(OPTION_LOAD_OUT && OPTION_VALID_IN); // see R6
            if (OPTION_LOAD_OUT && OPTION_VALID_IN) begin
                opt_done_q <= 1'b1;
                bor_lvl_q <= clamp_lvl(OPTION_BROWNOUT_LEVEL_IN); // see R4
                bor_dis_q <= OPTION_BROWNOUT_DISABLE_IN; // see R7
            end
            // hysteresis: assert below low edge, release above high edge
            if (below_lo) begin
                bor_rst_q <= 1'b1; // see R3
            end else if (above_hi) begin
                bor_rst_q <= 1'b0;
            end
            if (bor_active) begin
                rst_hold_q <= bor_rst_q || !opt_done_q; // see R5
            end else begin
                rst_hold_q <= !por_s || !pdr_s || !opt_done_q; // see R1 see R2
            end
        end
    end

    // power-on, power-down and RST_IN assert without waiting a clock; brown-out and release go through the register
    assign CHIP_RESET_OUT = RST_IN || rst_hold_q || !POR_ABOVE_IN ||
        !FALLING_SUPPLY_ABOVE_IN; // see R18 see R1 see R2

    wire det_sel = (DETECTOR_LEVEL_SELECT_IN == `SSC_LVL_EXT) ? ext_s :
        det_s[DETECTOR_LEVEL_SELECT_IN]; // see R9 see R10
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            DETECTOR_OUTPUT_FLAG_OUT <= 1'b0;
        end else if (DETECTOR_ENABLE_BIT_IN && dep_en) begin
            // flag high means supply below threshold
            DETECTOR_OUTPUT_FLAG_OUT <= !det_sel; // see R11 see R12
        end else begin
            DETECTOR_OUTPUT_FLAG_OUT <= 1'b0;
        end
    end
    assign EVENT_LINE16_OUT = DETECTOR_OUTPUT_FLAG_OUT; // see R12

    wire ref_req = bor_active || DETECTOR_ENABLE_BIT_IN || ADC_REF_REQ_IN ||
        LCD_REF_REQ_IN || COMP_REF_REQ_IN; // see R13
    wire ref_on;
    wire ref_rdy;
    wire ref_hold;
    ssc_vref_ctrl #(.START_CYC(VREF_START_CYC)) u_vref (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .request_in(ref_req),
        .lowpower_in(LOWPOWER_IN),
        .ulp_in(REFERENCE_OFF_IN_LOWPOWER_IN),
        .fwu_in(FAST_WAKEUP_SELECT_IN),
        .vref_on_out(ref_on),
        .ready_out(ref_rdy),
        .hold_wake_out(ref_hold),
        .dep_enable_out(dep_en)
    ); // see R14 see R15 see R16
    assign INTERNAL_REFERENCE_ON_OUT = ref_on;
    assign REFERENCE_READY_FLAG_OUT = ref_rdy; // see R17
    assign WAKE_HOLD_OUT = ref_hold;
    assign REF_DEPENDENTS_ENABLE_OUT = dep_en;
endmodule // ssc_top

// file: dv/ssc_ana_model.sv
// comparators and event-line edge counter
// assumes supply levels in millivolts from the bench
`timescale 1ns/1ps
module ssc_ana_model (
    // clock, reset, supply levels, event line
    input wire clk_in,
    input wire rst_in,
    input wire [11:0] vdd_in,
    input wire [11:0] ext_in,
    input wire evt_in,
    // comparators and events
    output wire por_out,
    output wire start_out,
    output reg [4:0] lo_out,
    output reg [4:0] hi_out,
    output reg [6:0] det_out,
    output wire ext_out,
    output reg [3:0] irq_out = 4'h0
);
    localparam [59:0] LO = {12'hAD2, 12'h9EC, 12'h8FC, 12'h794, 12'h69A};
    localparam [59:0] HI = {12'hBB8, 12'hAB4, 12'h9BA, 12'h834, 12'h708};
    integer i;
    reg evt_q = 1'b0;
    assign por_out = vdd_in > 12'h5DC;
    assign start_out = vdd_in > 12'h708;
    assign ext_out = ext_in > 12'h4B0;
    always @* begin
        for (i = 0; i < 5; i = i + 1) begin
            lo_out[i] = vdd_in > LO[i*12 +: 12];
            hi_out[i] = vdd_in > HI[i*12 +: 12];
        end
        for (i = 0; i < 7; i = i + 1) begin
            det_out[i] = vdd_in > 12'h73A + 12'h0C8 * i;
        end
    end
    // both edges enabled, so falling and rising supply both count
    // counting starts from reset so an unknown line before reset is never counted
    always @(posedge clk_in) begin
        if (rst_in) begin
            evt_q <= 1'b0;
            irq_out <= 4'h0;
        end else begin
            evt_q <= evt_in;
            irq_out <= irq_out + {3'h0, evt_in ^ evt_q};
        end
    end
endmodule // ssc_ana_model

// file: dv/ssc_top_assertions.sv
// port properties of the supervisor
// assumes bind into ssc_top
`timescale 1ns/1ps
module ssc_top_assertions (
    // clock, reset, inputs
    input wire CORE_CLK_IN,
    input wire RST_IN,
    input wire POR_ABOVE_IN,
    input wire FALLING_SUPPLY_ABOVE_IN,
    input wire OPTION_VALID_IN,
    input wire DETECTOR_ENABLE_BIT_IN,
    input wire ADC_REF_REQ_IN,
    input wire REFERENCE_OFF_IN_LOWPOWER_IN,
    input wire LOWPOWER_IN,
    // outputs
    input wire CHIP_RESET_OUT,
    input wire OPTION_LOAD_OUT,
    input wire DETECTOR_OUTPUT_FLAG_OUT,
    input wire EVENT_LINE16_OUT,
    input wire INTERNAL_REFERENCE_ON_OUT,
    input wire REFERENCE_READY_FLAG_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    property p_por; !POR_ABOVE_IN |-> CHIP_RESET_OUT; endproperty
    a_por: assert property (p_por) else $error("no reset at por");
    property p_pdr; !FALLING_SUPPLY_ABOVE_IN |-> CHIP_RESET_OUT; endproperty
    a_pdr: assert property (p_pdr) else $error("no reset at pdr");
    property p_opt; OPTION_LOAD_OUT && OPTION_VALID_IN |=> !OPTION_LOAD_OUT; endproperty
    a_opt: assert property (p_opt) else $error("load stuck");
    property p_evt; EVENT_LINE16_OUT == DETECTOR_OUTPUT_FLAG_OUT; endproperty
    a_evt: assert property (p_evt) else $error("event differs");
    property p_den; !DETECTOR_ENABLE_BIT_IN [*4] |-> !DETECTOR_OUTPUT_FLAG_OUT; endproperty
    a_den: assert property (p_den) else $error("flag while off");
    property p_ron;
        ADC_REF_REQ_IN && !(REFERENCE_OFF_IN_LOWPOWER_IN && LOWPOWER_IN)
            |=> INTERNAL_REFERENCE_ON_OUT;
    endproperty
    a_ron: assert property (p_ron) else $error("ref not on");
    property p_ulp; REFERENCE_OFF_IN_LOWPOWER_IN && LOWPOWER_IN |=> !INTERNAL_REFERENCE_ON_OUT; endproperty
    a_ulp: assert property (p_ulp) else $error("ref on in lp");
    property p_rdy; $rose(REFERENCE_READY_FLAG_OUT) |-> $past(INTERNAL_REFERENCE_ON_OUT); endproperty
    a_rdy: assert property (p_rdy) else $error("ready while off");
endmodule // ssc_top_assertions

// file: dv/ssc_top_tb_top.sv
// bench for ssc_top with comparator model
// assumes short reference startup count
`timescale 1ns/1ps
module ssc_top_tb_top;
    localparam [18:0] START = 19'h0_0014;
    reg clk = 1'b0, rst = 1'b1, vld, dis, en, reference_off_in_lowpower, fast_wakeup_select, lp, adc, lcd, cmp;
    reg [11:0] vdd, ext;
    reg [2:0] lvl, sel;
    wire por, st, ea, rst_o, ld, flag, evt, ref_on, rdy, hold, dep;
    wire [4:0] lo, hi;
    wire [6:0] det;
    wire [3:0] irq;
    integer err_count = 0, compares = 0, n;
    always #5 clk = ~clk;
    ssc_ana_model i_ana (.clk_in(clk), .rst_in(rst), .vdd_in(vdd), .ext_in(ext), .evt_in(evt),
        .por_out(por), .start_out(st), .lo_out(lo), .hi_out(hi), .det_out(det),
        .ext_out(ea), .irq_out(irq));
    ssc_top #(.VREF_START_CYC(START)) i_dut (.CORE_CLK_IN(clk), .RST_IN(rst),
        .POR_ABOVE_IN(por), .FALLING_SUPPLY_ABOVE_IN(por), .START_ABOVE_IN(st),
        .BROWNOUT_ABOVE_LOW_IN(lo), .BROWNOUT_ABOVE_HIGH_IN(hi), .DETECTOR_ABOVE_IN(det),
        .EXTERNAL_DETECTOR_ABOVE_IN(ea), .OPTION_VALID_IN(vld),
        .OPTION_BROWNOUT_LEVEL_IN(lvl), .OPTION_BROWNOUT_DISABLE_IN(dis),
        .DETECTOR_LEVEL_SELECT_IN(sel), .DETECTOR_ENABLE_BIT_IN(en),
        .REFERENCE_OFF_IN_LOWPOWER_IN(reference_off_in_lowpower), .FAST_WAKEUP_SELECT_IN(fast_wakeup_select), .LOWPOWER_IN(lp),
        .ADC_REF_REQ_IN(adc), .LCD_REF_REQ_IN(lcd), .COMP_REF_REQ_IN(cmp),
        .CHIP_RESET_OUT(rst_o), .OPTION_LOAD_OUT(ld), .DETECTOR_OUTPUT_FLAG_OUT(flag),
        .EVENT_LINE16_OUT(evt), .INTERNAL_REFERENCE_ON_OUT(ref_on),
        .REFERENCE_READY_FLAG_OUT(rdy), .WAKE_HOLD_OUT(hold), .REF_DEPENDENTS_ENABLE_OUT(dep));
    task step(input integer k); repeat (k) @(negedge clk); endtask
    task chk(input got, input exp); begin
        compares = compares + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0t got %b want %b", $time, got, exp);
        end
    end endtask
    task close_out; begin
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end endtask
    initial begin #100000; err_count = err_count + 1; close_out; end
    initial begin
        vdd = 12'h000; ext = 12'h7D0; {vld, dis, en, reference_off_in_lowpower, fast_wakeup_select, lp, adc, lcd, cmp} = 9'h000;
        lvl = 3'h2; sel = 3'h0;
        step(8); rst = 1'b0; step(1);
        chk(rst_o, 1'b1);
        vdd = 12'hBB8;
        for (n = 0; n < 20 && ld !== 1'b1; n = n + 1) step(1);
        chk(ld, 1'b1);
        vld = 1'b1; step(1); vld = 1'b0; step(1);
        chk(ld, 1'b0);
        for (n = 0; n < 20 && rst_o !== 1'b0; n = n + 1) step(1);
        chk(rst_o, 1'b0);
        $display("startup done");
        vdd = 12'h8CA;
        for (n = 0; n < 10 && rst_o !== 1'b1; n = n + 1) step(1);
        chk(rst_o, 1'b1);
        vdd = 12'h9B0; step(10);
        chk(rst_o, 1'b1);
        vdd = 12'h9C4;
        for (n = 0; n < 10 && rst_o !== 1'b0; n = n + 1) step(1);
        chk(rst_o, 1'b0);
        $display("brownout done");
        vdd = 12'hBB8; en = 1'b1;
        for (n = 0; n < 7; n = n + 1) begin
            sel = n[2:0]; step(5);
            chk(flag, n == 6);
            chk(evt, n == 6);
        end
        sel = 3'h7; step(5);
        chk(flag, 1'b0);
        ext = 12'h3E8; step(5);
        chk(flag, 1'b1);
        en = 1'b0; step(5);
        chk(flag, 1'b0);
        chk(irq === 4'h4, 1'b1);
        $display("detector done");
        adc = 1'b1; reference_off_in_lowpower = 1'b1; step(2);
        chk(ref_on, 1'b1);
        for (n = 0; n < 2; n = n + 1) begin
            fast_wakeup_select = n[0]; step(1); lp = 1'b1; step(3);
            chk(ref_on, 1'b0);
            chk(rdy, 1'b0);
            chk(dep, 1'b0);
            lp = 1'b0; step(3);
            chk(hold, ~fast_wakeup_select);
            chk(dep, 1'b0);
            step(START + 3);
            chk(rdy, 1'b1);
            chk(dep, 1'b1);
            chk(hold, 1'b0);
        end
        $display("reference done");
        // second reset: options disable brown-out, supply sits below level 2
        rst = 1'b1; dis = 1'b1; vdd = 12'h8CA; step(8); rst = 1'b0;
        for (n = 0; n < 20 && ld !== 1'b1; n = n + 1) step(1);
        chk(ld, 1'b1);
        vld = 1'b1; step(1); vld = 1'b0;
        for (n = 0; n < 20 && rst_o !== 1'b0; n = n + 1) step(1);
        chk(rst_o, 1'b0);
        $display("option disable done");
        vdd = 12'h5AA; #1;
        chk(rst_o, 1'b1);
        $display("por done");
        close_out;
    end
endmodule // ssc_top_tb_top
bind ssc_top ssc_top_assertions i_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
    .POR_ABOVE_IN(POR_ABOVE_IN), .FALLING_SUPPLY_ABOVE_IN(FALLING_SUPPLY_ABOVE_IN),
    .OPTION_VALID_IN(OPTION_VALID_IN), .DETECTOR_ENABLE_BIT_IN(DETECTOR_ENABLE_BIT_IN),
    .ADC_REF_REQ_IN(ADC_REF_REQ_IN), .LOWPOWER_IN(LOWPOWER_IN),
    .REFERENCE_OFF_IN_LOWPOWER_IN(REFERENCE_OFF_IN_LOWPOWER_IN),
    .CHIP_RESET_OUT(CHIP_RESET_OUT), .OPTION_LOAD_OUT(OPTION_LOAD_OUT),
    .DETECTOR_OUTPUT_FLAG_OUT(DETECTOR_OUTPUT_FLAG_OUT), .EVENT_LINE16_OUT(EVENT_LINE16_OUT),
    .INTERNAL_REFERENCE_ON_OUT(INTERNAL_REFERENCE_ON_OUT),
    .REFERENCE_READY_FLAG_OUT(REFERENCE_READY_FLAG_OUT));
